//--- src/sce_core.sv
// Stack cpu core executing short instructions from packed program words
`timescale 1ns/10ps
module sce_core #(
  parameter logic [15:0] RESET_ADDR = sce_pkg::RESET_PC,
  parameter int unsigned DEPTH = sce_pkg::STACK_DEPTH,
  // Start values; this subset has no opcode that brings data in
  parameter logic [sce_pkg::CW-1:0] RESET_TOS = '0,
  parameter logic [sce_pkg::CW-1:0] RESET_SOS = '0,
  parameter logic [sce_pkg::CW-1:0] DATA_FILL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Program memory read port, one cycle latency
  output logic prog_rd,
  output logic [15:0] prog_addr,
  input wire logic [15:0] prog_rdata,
  // Data memory write port
  output sce_pkg::sce_dwrite_t dwrite,
  // Observed state
  output logic [sce_pkg::CW-1:0] tos,
  output logic [15:0] addr_reg,
  output logic [15:0] pc
);
  localparam int unsigned DW = sce_pkg::DW;
  localparam int unsigned CW = sce_pkg::CW;

  sce_pkg::sce_state_t state_r;
  logic [15:0] word_r;
  logic [1:0] slot_r;
  logic [CW-1:0] t_r;
  logic [CW-1:0] s_r;
  logic [CW-1:0] ps_top;
  logic [CW-1:0] rs_top;
  logic [4:0] op;
  logic exec;
  logic pop_data;
  logic push_ret;
  logic pop_ret;
  logic word_end;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Slot 0 in the high bits, executed first
  always_comb
  begin
    case (slot_r)
      2'h0: op = word_r[14:10];
      2'h1: op = word_r[9:5];
      default: op = word_r[4:0];
    endcase
  end

  assign exec = (state_r == sce_pkg::SCE_EXEC);
  assign pop_data = exec && (op == sce_pkg::OP_PUSH_RETURN || op == sce_pkg::OP_MEMORY_WRITE_INDIRECT ||
                             op == sce_pkg::OP_STORE_INC || op == sce_pkg::OP_LOAD_ADDR ||
                             op == sce_pkg::OP_XOR);
  assign push_ret = exec && op == sce_pkg::OP_PUSH_RETURN;
  assign pop_ret = exec && op == sce_pkg::OP_RET;
  // Exit and idle end the word; later slots are never decoded
  assign word_end = op == sce_pkg::OP_RET || op == sce_pkg::OP_IDLE_SLOT_OP || slot_r == sce_pkg::LAST_SLOT;

  ////////////////////////////////////////////////////////////////////////////
  // Stacks

  sce_stack #(
    .WIDTH(CW),
    .DEPTH(DEPTH),
    .FILL(DATA_FILL)
  ) u_data_stack (
    .clock(clock),
    .rst(rst),
    .push(1'b0),
    .pop(pop_data),
    .din(s_r),
    .top(ps_top)
  );

  sce_stack #(
    .WIDTH(CW),
    .DEPTH(DEPTH)
  ) u_return_stack (
    .clock(clock),
    .rst(rst),
    .push(push_ret),
    .pop(pop_ret),
    .din(t_r),
    .top(rs_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_r <= sce_pkg::SCE_FETCH;
      word_r <= 16'h0000;
      slot_r <= 2'h0;
      pc <= RESET_ADDR;
    end
    else
    begin
      case (state_r)
        sce_pkg::SCE_FETCH:
        begin
          pc <= pc + 16'h0001;
          state_r <= sce_pkg::SCE_LOAD;
        end
        sce_pkg::SCE_LOAD:
        begin
          word_r <= prog_rdata;
          slot_r <= 2'h0;
          state_r <= sce_pkg::SCE_EXEC;
        end
        sce_pkg::SCE_EXEC:
        begin
          if (op == sce_pkg::OP_RET)
            pc <= rs_top[15:0];
          if (word_end)
            state_r <= sce_pkg::SCE_FETCH;
          else
            slot_r <= slot_r + 2'h1;
        end
        default:
          state_r <= sce_pkg::SCE_FETCH;
      endcase
    end
  end

  assign prog_rd = (state_r == sce_pkg::SCE_FETCH);
  assign prog_addr = pc;

  ////////////////////////////////////////////////////////////////////////////
  // Top and second of stack

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      t_r <= RESET_TOS;
      s_r <= RESET_SOS;
    end
    else if (exec)
    begin
      case (op)
        sce_pkg::OP_PUSH_RETURN, sce_pkg::OP_MEMORY_WRITE_INDIRECT, sce_pkg::OP_STORE_INC, sce_pkg::OP_LOAD_ADDR:
        begin
          // Carry comes back with the popped word
          t_r <= s_r;
          s_r <= ps_top;
        end
        sce_pkg::OP_ROTATE_BYTE_RIGHT:
          t_r <= {t_r[sce_pkg::CARRY_BIT], t_r[7:0], t_r[15:8]};
        sce_pkg::OP_SHIFT_LEFT:
          t_r <= {t_r[DW-1:0], 1'b0};
        sce_pkg::OP_SHIFT_RIGHT_ONE:
          t_r <= {1'b0, t_r[sce_pkg::SIGN_BIT], t_r[DW-1:1]};
        sce_pkg::OP_XOR:
        begin
          t_r <= t_r ^ s_r;
          s_r <= ps_top;
        end
        default:
          t_r <= t_r;
      endcase
    end
  end

  assign tos = t_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address register and data writes

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      addr_reg <= 16'h0000;
    else if (exec && op == sce_pkg::OP_LOAD_ADDR)
      addr_reg <= t_r[15:0];
    else if (exec && op == sce_pkg::OP_STORE_INC)
      addr_reg <= addr_reg + 16'h0001;
  end

  // Registered so the write lands one cycle after its slot
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      dwrite <= '0;
    else
    begin
      dwrite.wr <= exec && (op == sce_pkg::OP_MEMORY_WRITE_INDIRECT || op == sce_pkg::OP_STORE_INC);
      dwrite.addr <= addr_reg;
      dwrite.data <= t_r[15:0];
    end
  end
endmodule

//--- pkg/sce_pkg.sv
// Constants, opcodes and carrier types for the stack cpu short-instruction executor
// Operation
// - Opcode 28: second goes to top, pop data stack, old top to return stack.
// - Opcode 1: return stack top popped into program counter, carry kept.
// - Subroutine exit in any slot; earlier slots run, later slots skipped.
// - Opcode 14: rotate low sixteen top bits right by eight, carry kept.
// - Opcode 17: shift low sixteen top bits left one, bit zero cleared.
// - Left shift moves sign bit into carry so sign can be tested.
// - Opcode 18: shift right one, drop bit zero, keep sign, clear carry.
// - Opcode 15: write top at address register, pop, address unchanged.
// - Opcode 13: write top at address register, pop, then address plus one.
// - Opcode 29: top copied to address register, then data stack popped.
// - Opcode 20: pop second and XOR it into all top bits including carry.
// - Idle opcode returns sequencer to first slot and fetches next word.
package sce_pkg;
  localparam int unsigned DW = 16;
  localparam int unsigned CW = DW + 1;
  localparam int unsigned CARRY_BIT = DW;
  localparam int unsigned SIGN_BIT = DW - 1;
  localparam int unsigned OPW = 5;
  localparam int unsigned SLOTS = 3;
  localparam logic [1:0] LAST_SLOT = 2'h2;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam int unsigned STACK_DEPTH = 16;

  localparam logic [4:0] OP_RET = 5'h01;
  localparam logic [4:0] OP_STORE_INC = 5'h0d;
  localparam logic [4:0] OP_ROTATE_BYTE_RIGHT = 5'h0e;
  localparam logic [4:0] OP_MEMORY_WRITE_INDIRECT = 5'h0f;
  localparam logic [4:0] OP_SHIFT_LEFT = 5'h11;
  localparam logic [4:0] OP_SHIFT_RIGHT_ONE = 5'h12;
  localparam logic [4:0] OP_XOR = 5'h14;
  localparam logic [4:0] OP_PUSH_RETURN = 5'h1c;
  localparam logic [4:0] OP_LOAD_ADDR = 5'h1d;
  localparam logic [4:0] OP_IDLE_SLOT_OP = 5'h1e;

  typedef enum logic [1:0] {
    SCE_FETCH,
    SCE_LOAD,
    SCE_EXEC
  } sce_state_t;

  typedef struct packed {
    logic wr;
    logic [15:0] addr;
    logic [15:0] data;
  } sce_dwrite_t;
endpackage

//--- src/sce_stack.sv
// Circular stack memory with its top entry held in a register
`timescale 1ns/10ps
module sce_stack #(
  parameter int unsigned WIDTH = 17,
  parameter int unsigned DEPTH = 16,
  parameter logic [WIDTH-1:0] FILL = '0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Stack access
  input wire logic push,
  input wire logic pop,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] top
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] sp_r;
  logic [AW-1:0] below;

  assign below = sp_r - AW'(2);

  // Entries reset so an underflowing pop never returns unknown data
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    always_ff @(posedge clock or posedge rst)
    begin
      if (rst)
        mem[i] <= FILL;
      else if (push && sp_r == AW'(i))
        mem[i] <= din;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sp_r <= '0;
      top <= FILL;
    end
    else if (push)
    begin
      sp_r <= sp_r + AW'(1);
      top <= din;
    end
    else if (pop)
    begin
      // Underflow wraps silently, as a hardware stack does
      sp_r <= sp_r - AW'(1);
      top <= mem[below];
    end
  end
endmodule

//--- verif/sce_core_asserts.sv
// Port-level checker for the short-instruction core
`timescale 1ns/10ps
module sce_core_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Ports watched
  input wire logic prog_rd,
  input wire logic [15:0] prog_addr,
  input wire sce_pkg::sce_dwrite_t dwrite,
  input wire logic [sce_pkg::CW-1:0] tos,
  input wire logic [15:0] addr_reg,
  input wire logic [15:0] pc
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  chk_fetch_pc_step: assert property (prog_rd |=> pc == $past(pc) + 16'h1)
    else $error("pc not stepped");
  chk_word_slot_count: assert property (prog_rd |=> !prog_rd [*2] ##[1:3] prog_rd)
    else $error("bad slot count");
  chk_load_quiet: assert property (prog_rd |=> $stable(tos) && $stable(addr_reg) && !dwrite.wr ##1 $stable(tos))
    else $error("state moved in fetch");
  chk_store_data: assert property (dwrite.wr |-> dwrite.data == $past(tos[15:0]))
    else $error("store data wrong");
  chk_store_addr: assert property (dwrite.wr |-> dwrite.addr == $past(addr_reg))
    else $error("store address wrong");
  chk_store_addr_step: assert property (dwrite.wr |-> addr_reg - dwrite.addr <= 16'h1)
    else $error("address step wrong");
  chk_store_after_exec: assert property (dwrite.wr |-> !$past(prog_rd) && !$past(prog_rd, 2))
    else $error("store outside slot");
  chk_pc_jump_ends: assert property (!$stable(pc) |-> $past(prog_rd) || prog_rd)
    else $error("pc moved mid word");
  chk_fetch_addr: assert property (prog_rd |-> prog_addr == pc)
    else $error("fetch address wrong");
  cover property (dwrite.wr ##1 dwrite.wr);
  cover property (prog_rd ##3 prog_rd);
  cover property (prog_rd ##5 prog_rd);
endmodule
bind sce_core sce_core_asserts u_chk (.clock, .rst, .prog_rd, .prog_addr, .dwrite, .tos, .addr_reg, .pc);

//--- verif/sce_prog_mem.sv
// Program memory model answering one cycle after each read
`timescale 1ns/10ps
module sce_prog_mem (
  // Clock
  input wire logic clock,
  // Read port
  input wire logic prog_rd,
  input wire logic [15:0] prog_addr,
  output logic [15:0] prog_rdata
);
  logic [15:0] rom [0:15];
  initial prog_rdata = 16'h0000;
  // Data scrambled outside the answer cycle, never left stale
  always @(posedge clock)
    prog_rdata <= prog_rd ? rom[prog_addr[3:0]] : ~prog_rdata;
endmodule

//--- verif/stack_cpu_instruction_exec_tb.sv
// Self-checking bench for the short-instruction core
`timescale 1ns/10ps
module stack_cpu_instruction_exec_tb;
  logic clock, rst, prog_rd;
  logic [15:0] prog_addr, prog_rdata, addr_reg, pc;
  logic [sce_pkg::CW-1:0] tos;
  sce_pkg::sce_dwrite_t dwrite;
  int n_fail = 0, n_checks = 0, cyc = 0;
  logic [31:0] wq[$];
  // Distinct start values so every data path shows a non-zero result
  sce_core #(
    .RESET_TOS(17'h0a5d3),
    .RESET_SOS(17'h10ff0),
    .DATA_FILL(17'h13c96)
  ) uut (.clock, .rst, .prog_rd, .prog_addr, .prog_rdata, .dwrite, .tos, .addr_reg, .pc);
  sce_prog_mem mem (.clock, .prog_rd, .prog_addr, .prog_rdata);
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////
  // Write log and hang guard
  always @(negedge clock)
  begin
    cyc++;
    if (dwrite.wr === 1'b1)
      wq.push_back({dwrite.addr, dwrite.data});
    if (cyc > 2000)
    begin
      n_fail++;
      complete_run();
    end
  end
  function automatic logic [15:0] wd(input logic [4:0] a, b, c);
    return {1'b0, a, b, c};
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Filler word is three idle ops
  task automatic boot(input logic [15:0] w0, w1, input int n);
    rst = 1'b1;
    mem.rom = '{0: w0, 1: w1, default: 16'h7bde};
    repeat (8) @(negedge clock);
    wq.delete();
    rst = 1'b0;
    repeat (n) @(negedge clock);
  endtask
  ////////////////////////////////////////
  task automatic store_run();
    boot(wd(5'h0d, 5'h0d, 5'h0f), wd(5'h0f, 5'h1e, 5'h0d), 14);
    chk(32'(wq.size()), 32'h4, "store count");
    chk(wq[0], 32'h0000a5d3, "post increment first");
    chk(wq[1], 32'h00010ff0, "post increment second");
    chk(wq[2], 32'h00023c96, "plain store first");
    chk(wq[3], 32'h00023c96, "plain store second");
    chk(32'(addr_reg), 32'h2, "address kept");
    chk(32'(tos), 32'h13c96, "carry restored");
  endtask
  task automatic ret_run();
    boot(wd(5'h0d, 5'h0d, 5'h1d), wd(5'h1c, 5'h01, 5'h0d), 9);
    chk(32'(addr_reg), 32'h3c96, "address load");
    chk(32'({prog_rd, prog_addr}), 32'h13c96, "return target");
    chk(32'(tos), 32'h13c96, "return keeps top");
    chk(32'(wq.size()), 32'h2, "slot after return");
  endtask
  task automatic shift_run();
    boot(wd(5'h0e, 5'h11, 5'h12), wd(5'h14, 5'h1e, 5'h0d), 3);
    chk(32'(tos), 32'h0d3a5, "byte rotate");
    @(negedge clock);
    chk(32'(tos), 32'h1a74a, "shift left");
    @(negedge clock);
    chk(32'({prog_rd, prog_addr}), 32'h10001, "three slots");
    chk(32'(tos), 32'h0d3a5, "shift right");
    repeat (4) @(negedge clock);
    chk(32'({prog_rd, prog_addr}), 32'h10002, "idle ends word");
    chk(32'(tos), 32'h1dc55, "xor with carry");
    chk(32'(wq.size()), 32'h0, "skipped store");
  endtask
  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    store_run();
    ret_run();
    shift_run();
    complete_run();
  end
endmodule
